// file: hw/iffl_top.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "iffl_consts.svh"

// What this block does
// RQ1: Latched bit sets only when its fault rises and filtering conditions are met.
// RQ2: Any unmasked latched bit going from zero to one raises an interrupt request.
// RQ3: By default a read clears a latched bit only when its live bit is zero.
// RQ4: With clear-on-read-always set, a read clears latched bits whatever the live state.
// RQ5: A summary register shows which channels hold latched faults.
// RQ6: Minus battery-short and overvoltage bits clear only by reading another register.
// RQ7: Host reads every latched register after each fault signal.
// RQ8: With debounce on, a fault needs the programmed count of consecutive fault readings.
// RQ9: Debounce select codes 16, 8, 4 or none; resets to 4; not for supply short.
// RQ10: Supply-short-below-bias debounce is 16 counts when zero, 8 when one.
// RQ11: Scan interval select is continuous, 1 ms, 4 ms or 8 ms; resets to 4 ms.
// RQ12: The interval runs from the end of one full scan to the next start.
// RQ13: Continuous mode starts the next scan at once, with no idle gap.
// RQ14: Threshold doubling bit multiplies every threshold by two.
// RQ15: Averaging select: off, equal weighting, or old 0.75 and new 0.25.
// RQ16: With averaging the average must pass the threshold, for the full debounce count.
// RQ17: Bias load override bit forces averaging off for bias current faults.
// RQ18: Overtemperature override bit forces averaging off for overtemperature faults.
// RQ19: Without averaging, persistence time is scan interval times debounce count.
// RQ20: Continuous response time is 450 times channels plus 1000 scan clock periods.
// RQ21: Scan clock is 6.144 MHz, 5.644 MHz, or the 5 MHz oscillator on clock trouble.
// RQ22: Live bits and the first interrupt register bypass debounce and averaging.
// RQ23: In clear-always mode a cleared bit sets again only on a new rising fault.
// RQ24: A masked fault raises no interrupt request but is still latched.
// RQ25: An in-range reading restarts the debounce count from zero.
// RQ26: The reserved averaging code behaves as averaging off.
module iffl_top import iffl_pkg::*; #(
	parameter int SCAN_1_CYCLES = `IFFL_INTERVAL_1_US * `IFFL_CLK_MHZ,
	parameter int SCAN_4_CYCLES = `IFFL_INTERVAL_4_US * `IFFL_CLK_MHZ,
	parameter int SCAN_8_CYCLES = `IFFL_INTERVAL_8_US * `IFFL_CLK_MHZ
) (
	// Clock, reset and clock enable
	input logic pclk,
	input logic presetn,
	input logic clk_en,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Diagnostic converter
	input iffl_sample_type sample,
	input logic scan_done,
	output logic scan_start,
	output logic scan_idle,
	output logic [5:0] scan_channel_enable,
	// Unfiltered self-protection faults
	input logic [3:0] first_live,
	// Clock status
	input logic rate_family_44k,
	input logic clocks_bad,
	// Results
	output logic irq_request,
	output logic [11:0] response_periods,
	output logic [12:0] diag_clock_khz
);

	localparam int NP = `IFFL_NPOINT;
	localparam int NCH = `IFFL_NCH;

	iffl_regs_type r;
	iffl_regs_type next_r;
	iffl_verdict_type verdict;
	logic [7:0] idx;
	logic mapped;
	logic rd_done;
	logic wr_done;
	logic [8:0] eff_thresh;
	logic [1:0] eff_avg;
	logic [4:0] eff_target;

	function automatic logic ch_index(input logic [7:0] i);
		return (i >= `IFFL_IDX_CH_BASE) && (i < `IFFL_IDX_CH_BASE + 8'(NCH));
	endfunction : ch_index

	function automatic logic is_mapped(input logic [7:0] i);
		case (i)
			`IFFL_IDX_INT_CFG, `IFFL_IDX_MASK_A, `IFFL_IDX_MASK_B, `IFFL_IDX_FIRST,
			`IFFL_IDX_SUMMARY, `IFFL_IDX_PLUS_OV, `IFFL_IDX_MINUS_OV, `IFFL_IDX_BIAS,
			`IFFL_IDX_SCAN_EN, `IFFL_IDX_THRESH, `IFFL_IDX_SCAN_CFG,
			`IFFL_IDX_AVG_CFG: return 1'b1;
			default: return ch_index(i);
		endcase
	endfunction : is_mapped

	function automatic logic [7:0] reg_byte(input iffl_regs_type s, input logic [7:0] i);
		logic [7:0] b;
		b = 8'h00;
		case (i)
			`IFFL_IDX_INT_CFG: b[`IFFL_CLR_ALWAYS_BIT] = s.clr_always;
			`IFFL_IDX_MASK_A: b = s.mask_a;
			`IFFL_IDX_MASK_B: b = s.mask_b;
			`IFFL_IDX_FIRST: b = {s.first_ltch, 4'h0};
			`IFFL_IDX_SUMMARY: begin
				for (int k = 0; k < NCH; k++) begin
					b[7-k] = |s.latched[k*8 +: 8]; // RQ5
				end
				b[1] = s.latched[`IFFL_PT_SUPPLY_SHORT];
			end
			`IFFL_IDX_PLUS_OV: begin
				for (int k = 0; k < NCH; k++) begin
					b[7-k] = s.latched[`IFFL_PT_PLUS_OV+k];
				end
			end
			`IFFL_IDX_MINUS_OV: begin
				for (int k = 0; k < NCH; k++) begin
					b[7-k] = s.latched[`IFFL_PT_MINUS_OV+k];
				end
			end
			`IFFL_IDX_BIAS: begin
				b = {s.latched[`IFFL_PT_BIAS_HC], s.latched[`IFFL_PT_BIAS_LC],
					s.latched[`IFFL_PT_BIAS_OV], s.latched[`IFFL_PT_OVERTEMP], 4'h0};
			end
			`IFFL_IDX_SCAN_EN: b = {s.scan_en, 2'b00};
			`IFFL_IDX_THRESH: b = s.thresh;
			`IFFL_IDX_SCAN_CFG: b = s.scan_cfg;
			`IFFL_IDX_AVG_CFG: b = {s.avg_cfg, 4'h0};
			default: begin
				if (ch_index(i)) begin
					b = s.latched[int'(i - `IFFL_IDX_CH_BASE)*8 +: 8];
				end
			end
		endcase
		return b;
	endfunction : reg_byte

	// Points whose latched bit a read of register i may clear.
	function automatic logic [NP-1:0] clear_set(input logic [7:0] i);
		logic [NP-1:0] m;
		m = '0;
		case (i)
			`IFFL_IDX_SUMMARY: m[`IFFL_PT_SUPPLY_SHORT] = 1'b1;
			`IFFL_IDX_BIAS: begin
				m[`IFFL_PT_BIAS_HC] = 1'b1;
				m[`IFFL_PT_BIAS_LC] = 1'b1;
				m[`IFFL_PT_BIAS_OV] = 1'b1;
				m[`IFFL_PT_OVERTEMP] = 1'b1;
				// The minus battery shorts and both overvoltage groups are
				// cleared here, so reading their own registers leaves them set.
				for (int k = 0; k < NCH; k++) begin
					m[k*8] = 1'b1; // RQ6
					m[`IFFL_PT_PLUS_OV+k] = 1'b1; // RQ6
					m[`IFFL_PT_MINUS_OV+k] = 1'b1; // RQ6
				end
			end
			default: begin
				if (ch_index(i)) begin
					m[int'(i - `IFFL_IDX_CH_BASE)*8 +: 8] = 8'hFE; // RQ6
				end
			end
		endcase
		return m;
	endfunction : clear_set

	function automatic logic point_masked(input iffl_regs_type s, input int p);
		if (p < NCH * 8) begin
			return s.mask_a[7 - p / 8];
		end else if (p < `IFFL_PT_BIAS_HC) begin
			return s.mask_a[1];
		end
		return s.mask_a[0];
	endfunction : point_masked

	function automatic logic [2:0] count_ones(input logic [5:0] v);
		logic [2:0] n;
		n = 3'd0;
		for (int k = 0; k < 6; k++) begin
			n = n + {2'b00, v[k]};
		end
		return n;
	endfunction : count_ones

	assign idx = paddr[9:2];
	assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) && is_mapped(idx);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign rd_done = psel && penable && !pwrite && mapped && clk_en;
	assign wr_done = psel && penable && pwrite && mapped;

	assign eff_thresh = r.scan_cfg[`IFFL_DOUBLE_BIT] ? {r.thresh, 1'b0} : {1'b0, r.thresh}; // RQ14

	// Per-reading filter settings.
	always_comb begin
		eff_avg = r.avg_cfg[`IFFL_AVG_SEL_HI-4:`IFFL_AVG_SEL_LO-4];
		if (eff_avg == 2'd3) begin
			eff_avg = 2'd0; // RQ26
		end
		if ((sample.id == 7'(`IFFL_PT_BIAS_HC) || sample.id == 7'(`IFFL_PT_BIAS_LC))
			&& r.avg_cfg[`IFFL_BIAS_AVG_OFF_BIT-4]) begin
			eff_avg = 2'd0; // RQ17
		end
		if (sample.id == 7'(`IFFL_PT_OVERTEMP) && r.avg_cfg[`IFFL_TEMP_AVG_OFF_BIT-4]) begin
			eff_avg = 2'd0; // RQ18
		end
		if (sample.id == 7'(`IFFL_PT_SUPPLY_SHORT)) begin
			eff_target = r.scan_cfg[`IFFL_SUPPLY_DBN_BIT] ? 5'd8 : 5'd16; // RQ10
		end else begin
			case (r.scan_cfg[`IFFL_DBN_SEL_HI:`IFFL_DBN_SEL_LO])
				2'd0: eff_target = 5'd16; // RQ9
				2'd1: eff_target = 5'd8; // RQ9
				2'd2: eff_target = 5'd4; // RQ9
				default: eff_target = 5'd1; // RQ9
			endcase
		end
	end

	iffl_filter u_filter (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.sample(sample),
		.thresh(eff_thresh),
		.avg_mode(eff_avg),
		.target(eff_target),
		.verdict(verdict)
	);

	iffl_scan_timer #(
		.CYC_1(SCAN_1_CYCLES),
		.CYC_4(SCAN_4_CYCLES),
		.CYC_8(SCAN_8_CYCLES)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.interval_sel(r.scan_cfg[`IFFL_SCAN_SEL_HI:`IFFL_SCAN_SEL_LO]), // RQ11
		.scan_done(scan_done),
		.scan_start(scan_start),
		.scan_idle(scan_idle)
	);

	always_comb begin
		logic [NP-1:0] live_now;
		logic [NP-1:0] set_now;
		logic [NP-1:0] clr_now;
		logic [3:0] first_set;
		logic [3:0] first_clr;
		logic fresh;
		live_now = r.live;
		set_now = '0;
		clr_now = '0;
		first_set = 4'h0;
		first_clr = 4'h0;
		fresh = 1'b0;
		next_r = r;

		if (verdict.valid) begin
			live_now[verdict.id] = verdict.live; // RQ22
			// Only a fresh rise of the filtered state sets a bit again.
			set_now[verdict.id] = verdict.rise; // RQ23
		end
		next_r.live = live_now;

		first_set = first_live & ~r.first_prev; // RQ22
		next_r.first_prev = first_live;

		if (rd_done) begin
			if (r.clr_always) begin
				clr_now = clear_set(idx); // RQ4
			end else begin
				clr_now = clear_set(idx) & ~live_now; // RQ3
			end
			if (idx == `IFFL_IDX_FIRST) begin
				first_clr = r.clr_always ? 4'hF : ~first_live;
			end
		end
		// A fault arriving in the same cycle as its clearing read is kept.
		next_r.latched = (r.latched & ~clr_now) | set_now; // RQ1
		next_r.first_ltch = (r.first_ltch & ~first_clr) | first_set;

		for (int p = 0; p < NP; p++) begin
			if (set_now[p] && !r.latched[p] && !point_masked(r, p)) begin
				fresh = 1'b1; // RQ24
			end
		end
		if (|(first_set & ~r.first_ltch & ~r.mask_b[7:4])) begin
			fresh = 1'b1; // RQ24
		end
		next_r.irq = fresh; // RQ2

		if (psel && !penable) begin
			next_r.prdata = {24'h00_0000, reg_byte(r, idx)};
		end

		if (wr_done) begin
			case (idx)
				`IFFL_IDX_INT_CFG: next_r.clr_always = pwdata[`IFFL_CLR_ALWAYS_BIT];
				`IFFL_IDX_MASK_A: next_r.mask_a = pwdata[7:0];
				`IFFL_IDX_MASK_B: next_r.mask_b = {pwdata[7:4], 4'h0};
				`IFFL_IDX_SCAN_EN: next_r.scan_en = pwdata[7:2];
				`IFFL_IDX_THRESH: next_r.thresh = pwdata[7:0];
				`IFFL_IDX_SCAN_CFG: next_r.scan_cfg = pwdata[7:0];
				`IFFL_IDX_AVG_CFG: next_r.avg_cfg = pwdata[7:4];
				default: next_r.scan_en = r.scan_en;
			endcase
		end

		next_r.resp = `IFFL_RESP_PER_CH * {9'h000, count_ones(r.scan_en)} + `IFFL_RESP_BASE; // RQ20
		if (clocks_bad) begin
			next_r.khz = `IFFL_DIAG_OSC_KHZ; // RQ21
		end else if (rate_family_44k) begin
			next_r.khz = `IFFL_DIAG_44K_KHZ; // RQ21
		end else begin
			next_r.khz = `IFFL_DIAG_48K_KHZ; // RQ21
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{
				scan_cfg: `IFFL_SCAN_CFG_RST,
				avg_cfg: `IFFL_AVG_CFG_RST,
				thresh: `IFFL_THRESH_RST,
				scan_en: `IFFL_SCAN_EN_RST,
				resp: 12'h000,
				khz: 13'h0000,
				default: '0
			};
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign irq_request = r.irq;
	assign response_periods = r.resp;
	assign diag_clock_khz = r.khz;
	assign scan_channel_enable = r.scan_en;

endmodule : iffl_top

// file: hw/iffl_consts.svh
`ifndef IFFL_CONSTS_SVH
`define IFFL_CONSTS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define IFFL_IDX_INT_CFG 8'h28
`define IFFL_IDX_MASK_A 8'h2A
`define IFFL_IDX_MASK_B 8'h2B
`define IFFL_IDX_FIRST 8'h2C
`define IFFL_IDX_SUMMARY 8'h2D
`define IFFL_IDX_CH_BASE 8'h2E
`define IFFL_IDX_PLUS_OV 8'h35
`define IFFL_IDX_MINUS_OV 8'h36
`define IFFL_IDX_BIAS 8'h37
`define IFFL_IDX_SCAN_EN 8'h64
`define IFFL_IDX_THRESH 8'h65
`define IFFL_IDX_SCAN_CFG 8'h67
`define IFFL_IDX_AVG_CFG 8'h68

// Reset values.
`define IFFL_SCAN_CFG_RST 8'hB8
`define IFFL_AVG_CFG_RST 4'h0
`define IFFL_THRESH_RST 8'h80
`define IFFL_SCAN_EN_RST 6'h3F

// Field positions.
`define IFFL_SCAN_SEL_HI 7
`define IFFL_SCAN_SEL_LO 6
`define IFFL_DBN_SEL_HI 3
`define IFFL_DBN_SEL_LO 2
`define IFFL_SUPPLY_DBN_BIT 1
`define IFFL_DOUBLE_BIT 0
`define IFFL_AVG_SEL_HI 7
`define IFFL_AVG_SEL_LO 6
`define IFFL_BIAS_AVG_OFF_BIT 5
`define IFFL_TEMP_AVG_OFF_BIT 4
`define IFFL_CLR_ALWAYS_BIT 0

// Fault point numbering of the sample stream.
`define IFFL_NCH 6
`define IFFL_NPOINT 65
`define IFFL_PT_PLUS_OV 48
`define IFFL_PT_MINUS_OV 54
`define IFFL_PT_BIAS_HC 60
`define IFFL_PT_BIAS_LC 61
`define IFFL_PT_BIAS_OV 62
`define IFFL_PT_SUPPLY_SHORT 63
`define IFFL_PT_OVERTEMP 64

// Timing.
`define IFFL_CLK_MHZ 25
`define IFFL_INTERVAL_1_US 1000
`define IFFL_INTERVAL_4_US 4000
`define IFFL_INTERVAL_8_US 8000
`define IFFL_RESP_PER_CH 12'd450
`define IFFL_RESP_BASE 12'd1000
`define IFFL_DIAG_48K_KHZ 13'd6144
`define IFFL_DIAG_44K_KHZ 13'd5644
`define IFFL_DIAG_OSC_KHZ 13'd5000

`endif

// file: hw/iffl_pkg.sv
`include "iffl_consts.svh"

package iffl_pkg;

	typedef struct packed {
		logic valid;
		logic [6:0] id;
		logic [9:0] value;
	} iffl_sample_type;

	typedef struct packed {
		logic valid;
		logic [6:0] id;
		logic live;
		logic rise;
	} iffl_verdict_type;

	typedef enum logic [1:0] {IFFL_SCAN_KICK, IFFL_SCAN_RUN, IFFL_SCAN_WAIT} iffl_scan_state_type;

	typedef struct packed {
		iffl_scan_state_type state;
		logic [17:0] count;
		logic start;
	} iffl_timer_type;

	typedef struct packed {
		logic [`IFFL_NPOINT-1:0][9:0] avg;
		logic [`IFFL_NPOINT-1:0][4:0] cnt;
		logic [`IFFL_NPOINT-1:0] flt;
		iffl_verdict_type out;
	} iffl_filter_type;

	typedef struct packed {
		logic [7:0] scan_cfg;
		logic [3:0] avg_cfg;
		logic clr_always;
		logic [7:0] mask_a;
		logic [7:0] mask_b;
		logic [7:0] thresh;
		logic [5:0] scan_en;
		logic [`IFFL_NPOINT-1:0] latched;
		logic [`IFFL_NPOINT-1:0] live;
		logic [3:0] first_ltch;
		logic [3:0] first_prev;
		logic [31:0] prdata;
		logic irq;
		logic [11:0] resp;
		logic [12:0] khz;
	} iffl_regs_type;

endpackage : iffl_pkg

// file: hw/iffl_scan_timer.sv
`timescale 1ns/1ns

module iffl_scan_timer import iffl_pkg::*; #(
	parameter int CYC_1 = 25000,
	parameter int CYC_4 = 100000,
	parameter int CYC_8 = 200000
) (
	// Clock and reset
	input logic pclk,
	input logic presetn,
	input logic clk_en,
	// Control
	input logic [1:0] interval_sel,
	input logic scan_done,
	// Status
	output logic scan_start,
	output logic scan_idle
);

	iffl_timer_type r;
	iffl_timer_type next_r;
	logic [17:0] wait_len;

	always_comb begin
		case (interval_sel)
			2'd1: wait_len = 18'(CYC_1 - 1);
			2'd2: wait_len = 18'(CYC_4 - 1);
			default: wait_len = 18'(CYC_8 - 1);
		endcase
	end

	// The gap runs from the end of one full scan to the start of the next.
	always_comb begin
		next_r = r;
		next_r.start = 1'b0;
		case (r.state)
			IFFL_SCAN_KICK: begin
				next_r.start = 1'b1;
				next_r.state = IFFL_SCAN_RUN;
			end
			IFFL_SCAN_RUN: begin
				if (scan_done) begin
					if (interval_sel == 2'd0) begin
						next_r.start = 1'b1; // RQ13
					end else begin
						next_r.count = wait_len; // RQ12
						next_r.state = IFFL_SCAN_WAIT;
					end
				end
			end
			IFFL_SCAN_WAIT: begin
				if (r.count == 18'h0_0000) begin
					next_r.start = 1'b1; // RQ11
					next_r.state = IFFL_SCAN_RUN;
				end else begin
					next_r.count = r.count - 18'h0_0001;
				end
			end
			default: next_r.state = IFFL_SCAN_KICK;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{state: IFFL_SCAN_KICK, default: '0};
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign scan_start = r.start;
	assign scan_idle = (r.state == IFFL_SCAN_WAIT);

endmodule : iffl_scan_timer

// file: hw/iffl_filter.sv
`timescale 1ns/1ns
`include "iffl_consts.svh"

module iffl_filter import iffl_pkg::*; (
	// Clock and reset
	input logic pclk,
	input logic presetn,
	input logic clk_en,
	// Reading and its settings
	input iffl_sample_type sample,
	input logic [8:0] thresh,
	input logic [1:0] avg_mode,
	input logic [4:0] target,
	// Verdict, one cycle after the reading
	output iffl_verdict_type verdict
);

	iffl_filter_type r;
	iffl_filter_type next_r;

	always_comb begin
		logic [9:0] old;
		logic [11:0] sum;
		logic [9:0] mean;
		logic raw;
		logic beyond;
		logic [4:0] c;
		old = r.avg[sample.id];
		sum = 12'h000;
		mean = sample.value;
		raw = 1'b0;
		beyond = 1'b0;
		c = 5'h00;
		next_r = r;
		next_r.out = '0;
		if (sample.valid && sample.id < 7'(`IFFL_NPOINT)) begin
			raw = sample.value > {1'b0, thresh}; // RQ22
			case (avg_mode)
				2'd1: begin
					sum = {2'b00, old} + {2'b00, sample.value};
					mean = sum[10:1]; // RQ15
				end
				2'd2: begin
					sum = {2'b00, old} + {1'b0, old, 1'b0} + {2'b00, sample.value};
					mean = sum[11:2]; // RQ15
				end
				default: mean = sample.value;
			endcase
			next_r.avg[sample.id] = mean;
			beyond = (avg_mode != 2'd0) ? (mean > {1'b0, thresh}) : raw; // RQ16
			if (beyond) begin
				c = r.cnt[sample.id];
				if (c < target) begin
					c = c + 5'h01; // RQ8
				end
			end
			// An in-range reading restarts the count.
			next_r.cnt[sample.id] = c; // RQ25
			next_r.flt[sample.id] = beyond && (c >= target); // RQ19
			next_r.out.valid = 1'b1;
			next_r.out.id = sample.id;
			next_r.out.live = raw;
			next_r.out.rise = beyond && (c >= target) && !r.flt[sample.id]; // RQ1
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign verdict = r.out;

endmodule : iffl_filter

// file: sim/iffl_top_asserts.sv
`timescale 1ns/1ns

module iffl_top_asserts import iffl_pkg::*; (
	// Clock and reset
	input logic pclk,
	input logic presetn,
	input logic clk_en,
	// Register bus
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	// Diagnostic converter
	input iffl_sample_type sample,
	input logic scan_done,
	input logic scan_start,
	input logic scan_idle,
	input logic [5:0] scan_channel_enable,
	// Faults, clock status and results
	input logic [3:0] first_live,
	input logic rate_family_44k,
	input logic clocks_bad,
	input logic irq_request,
	input logic [11:0] response_periods,
	input logic [12:0] diag_clock_khz
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Cycles since the last cause; a request with no fresh reading or first_live change behind it is spurious.
	logic [2:0] quiet;
	logic [3:0] first_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet <= 3'h7;
			first_q <= 4'h0;
		end else begin
			first_q <= first_live;
			if (sample.valid || first_live != first_q)
				quiet <= 3'h0;
			else if (quiet != 3'h7)
				quiet <= quiet + 3'h1;
		end
	end

	sequence s_access;
		psel && penable;
	endsequence

	a_ready_access: assert property (s_access |-> pready)
		else $error("pready low in access phase");
	a_err_unmapped: assert property (s_access ##0 (paddr == 12'h000) |-> pslverr)
		else $error("no error for unmapped address");
	a_err_misaligned: assert property (s_access ##0 (paddr[1:0] != 2'h0) |-> pslverr)
		else $error("no error for misaligned address");
	a_err_only_access: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	a_read_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_start_single: assert property (scan_start |=> !scan_start)
		else $error("scan start longer than one cycle");
	a_resp_formula: assert property ($past(presetn) |-> response_periods >= 12'h5AA &&
		response_periods <= 12'hE74 && (response_periods - 12'h3E8) % 12'h1C2 == 12'h000)
		else $error("response periods off formula");
	a_clock_select: assert property ($past(presetn) && $past(clk_en) |->
		diag_clock_khz == ($past(clocks_bad) ? 13'h1388 :
		$past(rate_family_44k) ? 13'h160C : 13'h1800))
		else $error("scan clock rate wrong");
	a_irq_cause: assert property (irq_request |-> quiet <= 3'h3)
		else $error("interrupt request without cause");
endmodule : iffl_top_asserts

bind iffl_top iffl_top_asserts u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .sample, .scan_done, .scan_start,
	.scan_idle, .scan_channel_enable, .first_live, .rate_family_44k, .clocks_bad,
	.irq_request, .response_periods, .diag_clock_khz);

// file: sim/iffl_host.sv
`timescale 1ns/1ns
`include "iffl_consts.svh"

module iffl_host import iffl_pkg::*; (
	// Bus clock
	input logic pclk,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	// Answer
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// Reads every latched register, since some bits only clear from another register.
	task automatic read_all();
		logic [31:0] q;
		logic e;
		for (int i = `IFFL_IDX_FIRST; i <= `IFFL_IDX_BIAS; i++) begin
			if (i != 8'h34)
				xfer(1'b0, 12'(i * 4), 32'h0000_0000, q, e);
		end
	endtask : read_all
endmodule : iffl_host

// file: sim/tb.sv
`timescale 1ns/1ns
`include "iffl_consts.svh"

module tb import iffl_pkg::*;;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
	logic scan_done, scan_start, scan_idle, rate_family_44k, clocks_bad, irq_request;
	logic [11:0] paddr, response_periods;
	logic [31:0] pwdata, prdata, q;
	logic [5:0] scan_channel_enable;
	logic [3:0] first_live;
	logic [12:0] diag_clock_khz;
	iffl_sample_type sample;
	int err_total, samples_checked, irq_cnt, cyc, n;
	int dbn [4] = '{16, 8, 4, 1};
	int gap [4] = '{1, 6, 11, 21};
	logic [31:0] kz [3] = '{32'h0000_1800, 32'h0000_160C, 32'h0000_1388};
	// Rows: average setting, point, readings needed, register, bit.
	logic [39:0] rows [5] = '{40'h40_0702_2E80, 40'h80_0604_2E40, 40'hC0_0401_2E10,
		40'h50_4001_3710, 40'h60_3C01_3780};

	iffl_top #(.SCAN_1_CYCLES(5), .SCAN_4_CYCLES(10), .SCAN_8_CYCLES(20)) u_dut (.pclk,
		.presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sample, .scan_done, .scan_start, .scan_idle, .scan_channel_enable,
		.first_live, .rate_family_44k, .clocks_bad, .irq_request, .response_periods,
		.diag_clock_khz);
	iffl_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(negedge pclk) irq_cnt += int'(irq_request === 1'b1);

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic x;
		u_host.xfer(1'b1, {2'b00, idx, 2'b00}, {24'h00_0000, d}, r, x);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
		logic [31:0] r;
		logic x;
		u_host.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000, r, x);
		cmp(r & {24'hFF_FFFF, m}, {24'h00_0000, exp});
	endtask : rd

	task automatic hit(input logic [6:0] id, input logic [9:0] v);
		@(posedge pclk);
		sample <= '{1'b1, id, v};
		@(posedge pclk);
		sample.valid <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : hit

	task automatic latch_run(input logic [6:0] id, input int k, input logic [7:0] idx,
		input logic [7:0] m);
		repeat (k - 1) hit(id, 10'h0C8);
		rd(idx, m, 8'h00);
		hit(id, 10'h0C8);
		rd(idx, m, m);
	endtask : latch_run

	initial begin
		{presetn, scan_done, first_live, rate_family_44k, clocks_bad} = '0;
		clk_en = 1'b1;
		sample = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(`IFFL_IDX_SCAN_CFG, 8'hFF, 8'hB8);
		rd(`IFFL_IDX_AVG_CFG, 8'hFF, 8'h00);
		wr(`IFFL_IDX_AVG_CFG, 8'hFF);
		rd(`IFFL_IDX_AVG_CFG, 8'hFF, 8'hF0);
		wr(`IFFL_IDX_AVG_CFG, 8'h00);
		clk_en <= 1'b0;
		wr(`IFFL_IDX_THRESH, 8'h40);
		clk_en <= 1'b1;
		rd(`IFFL_IDX_THRESH, 8'hFF, 8'h80);
		u_host.xfer(1'b0, 12'h000, 32'h0000_0000, q, e);
		cmp({q[31:1], e}, 32'h0000_0001);
		u_host.xfer(1'b0, 12'h19D, 32'h0000_0000, q, e);
		// The decoder drops the low address bits, so the scan word comes back with the error.
		cmp({q[31:1], e}, 32'h0000_00B9);
		cmp({20'h0_0000, response_periods}, 32'h0000_0E74);
		wr(`IFFL_IDX_SCAN_EN, 8'h80);
		repeat (2) @(posedge pclk);
		cmp({20'h0_0000, response_periods}, 32'h0000_05AA);
		cmp(32'(scan_channel_enable), 32'h0000_0020);
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			{clocks_bad, rate_family_44k} <= 2'(i);
			repeat (3) @(posedge pclk);
			cmp({19'h0_0000, diag_clock_khz}, kz[i]);
		end
		{clocks_bad, rate_family_44k} <= 2'b00;
		$display("test bus and status done");
		for (int c = 0; c < 4; c++) begin
			wr(`IFFL_IDX_SCAN_CFG, 8'hB0 | 8'(c << 2));
			if (c == 2) begin
				repeat (3) hit(7'h05, 10'h0C8);
				hit(7'h05, 10'h00A);
			end
			latch_run(7'h05, dbn[c], `IFFL_IDX_CH_BASE, 8'h20);
			rd(`IFFL_IDX_SUMMARY, 8'h80, 8'h80);
			rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h20);
			hit(7'h05, 10'h00A);
			rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h20);
			rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h00);
		end
		cmp(irq_cnt, 32'h0000_0004);
		for (int b = 0; b < 2; b++) begin
			wr(`IFFL_IDX_SCAN_CFG, 8'hB8 | 8'(b << 1));
			latch_run(7'h3F, 16 >> b, `IFFL_IDX_SUMMARY, 8'h02);
			hit(7'h3F, 10'h00A);
			rd(`IFFL_IDX_SUMMARY, 8'h02, 8'h02);
		end
		$display("test debounce done");
		wr(`IFFL_IDX_SCAN_CFG, 8'hBD);
		hit(7'h05, 10'h0C8);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h00);
		hit(7'h05, 10'h12C);
		wr(`IFFL_IDX_INT_CFG, 8'h01);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h20);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h00);
		hit(7'h05, 10'h12C);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h00);
		hit(7'h05, 10'h00A);
		hit(7'h05, 10'h12C);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h20);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h00);
		wr(`IFFL_IDX_INT_CFG, 8'h00);
		wr(`IFFL_IDX_SCAN_CFG, 8'hBC);
		hit(7'h05, 10'h00A);
		$display("test clear modes done");
		hit(7'h00, 10'h12C);
		hit(7'h00, 10'h00A);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h01);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h01);
		u_host.read_all();
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h00);
		wr(`IFFL_IDX_MASK_A, 8'h80);
		n = irq_cnt;
		hit(7'h05, 10'h12C);
		rd(`IFFL_IDX_CH_BASE, 8'hFF, 8'h20);
		cmp(irq_cnt, n);
		hit(7'h05, 10'h00A);
		wr(`IFFL_IDX_MASK_A, 8'h00);
		u_host.read_all();
		@(posedge pclk);
		first_live <= 4'h1;
		repeat (4) @(posedge pclk);
		rd(`IFFL_IDX_FIRST, 8'hFF, 8'h10);
		cmp(irq_cnt, n + 1);
		$display("test cross clear and mask done");
		for (int i = 0; i < 5; i++) begin
			wr(`IFFL_IDX_AVG_CFG, rows[i][39:32]);
			latch_run(rows[i][30:24], rows[i][23:16], rows[i][15:8], rows[i][7:0]);
		end
		$display("test averaging done");
		for (int s = 0; s < 4; s++) begin
			wr(`IFFL_IDX_SCAN_CFG, 8'h3C | 8'(s << 6));
			@(posedge pclk);
			scan_done <= 1'b1;
			@(posedge pclk);
			scan_done <= 1'b0;
			n = 0;
			do begin
				@(negedge pclk);
				n++;
				if (n == 1) begin
					cmp(32'(scan_idle), 32'(s != 0));
				end
			end while (scan_start !== 1'b1);
			cmp(n, gap[s]);
		end
		$display("test scan timer done");
		complete_run();
	end
endmodule : tb
